// ===== hdl/pcm_pkg.sv
// constants, register map and field layout of the clock multiplier/lock block
// assumes a single core clock and an APB register port
package pcm_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BOOST = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_GPIO = 8'h18;
    localparam logic [7:0] ADDR_PLL_BASE = 8'h20;
    localparam logic [7:0] ADDR_PLL_STRIDE = 8'h10;
    localparam logic [7:0] OFS_RATIO = 8'h00;
    localparam logic [7:0] OFS_SHIFT = 8'h04;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_LOCKPIN_LSB = 4;
    localparam int CTRL_EXTOUT_LSB = 8;
    localparam int CTRL_EXTFB_LSB = 12;
    localparam int CTRL_LVDS_LSB = 16;
    localparam int RATIO_M_LSB = 0;
    localparam int RATIO_K_LSB = 8;
    localparam int RATIO_N_LSB = 16;
    localparam int RATIO_V_LSB = 24;
    localparam int SHIFT_PH_LSB = 0;
    localparam int SHIFT_DLY_LSB = 16;
    localparam int SHIFT_DEC_BIT = 31;
    localparam int GPIO_OE_LSB = 4;
    localparam int IRQ_LOSS_LSB = 4;
    localparam int IRQ_RANGE_BIT = 8;
    localparam int IRQ_COMBO_BIT = 9;
    localparam int STAT_PIN_LSB = 4;
    // ----------------------------------------
    // limits and reset values
    // ----------------------------------------
    localparam logic [7:0] MK_MIN = 8'h02;
    localparam logic [7:0] MK_MAX = 8'hA0;
    localparam logic [7:0] NV_MIN = 8'h01;
    localparam logic [7:0] NV_MAX = 8'h10;
    localparam logic [7:0] RST_M = 8'h02;
    localparam logic [7:0] RST_K = 8'h02;
    localparam logic [4:0] RST_N = 5'h01;
    localparam logic [4:0] RST_V = 5'h01;
    localparam int ACC_W = 12;
    localparam int QUARTERS = 4;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_FREQ_MHZ = 250;
    localparam int LOCK_TIME_US = 10;
    localparam int LOCK_CYC = LOCK_TIME_US * CLK_FREQ_MHZ;
    localparam int LOCK_CNT_W = $clog2(LOCK_CYC + 1);
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {BOOST_X1, BOOST_X2, BOOST_X4, BOOST_BAD} pcm_boost_t;
endpackage

// ===== hdl/pcm_top.sv
// clock multiplier / lock block: up to four independent digital pll models
// assumes one core clock, synchronous pins, apb master, external board loop
// Functional notes
// R1: out freq = in * m / (n*k or n*v)
// R2: pre and second post divider limited 1..16
// R3: phase shifts only in 90 degree steps
// R4: delay up or down, at most one period
// R5: lock output rises once pll locked
// R6: lock pin optional, otherwise plain gpio
// R7: up to four independent plls, small variant two
// R8: two plls may serve lvds sampling
// R9: board feeds shared pin only, secondary unused
// R10: only legal boost factor pairs accepted
// R11: clock may leave chip, feedback may loop externally
// R12: tracking starts only after configuration completes
// R13: lock reached within 10 us
// R14: lock low during config or bad reference
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module pcm_top
    import pcm_pkg::*;
#(
    parameter int NUM_PLL = 4,
    parameter int LVDS_PLLS = 2
)(
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic CONFIG_DONE_I,
    input wire logic REF_VALID_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [NUM_PLL-1:0] EXT_FB_I,
    input wire logic [NUM_PLL-1:0] LOCK_PIN_I,
    output logic [NUM_PLL-1:0] LOCK_PIN_O,
    output logic [NUM_PLL-1:0] LOCK_PIN_OE_O,
    output logic [NUM_PLL-1:0] CLK_K_O,
    output logic [NUM_PLL-1:0] CLK_V_O,
    output logic [NUM_PLL-1:0] CLK_PAD_O,
    output logic [NUM_PLL-1:0] CLK_PAD_OE_O,
    output logic [NUM_PLL-1:0] SER_STB_O,
    output logic IRQ_O
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        in_rng = (v >= lo) && (v <= hi);
    endfunction

    // accumulator advance, modulo the divider product
    function automatic logic [ACC_W-1:0] step(input logic [ACC_W-1:0] acc, input logic [7:0] m,
                                              input logic [ACC_W-1:0] md);
        logic [ACC_W+1:0] s;
        s = {2'b00, acc} + {{(ACC_W-6){1'b0}}, m};
        step = ACC_W'(s % {2'b00, md});
    endfunction

    // phase offset: quarter steps plus signed delay clamped below one period
    function automatic logic [ACC_W-1:0] offs(input logic [1:0] ph, input logic [ACC_W-1:0] dly,
                                              input logic dec, input logic [ACC_W-1:0] md);
        logic [ACC_W+1:0] q;
        logic [ACC_W-1:0] d;
        logic [ACC_W+1:0] t;
        q = (ACC_W+2)'(({2'b00, md} * {{ACC_W{1'b0}}, ph}) / QUARTERS); // R3
        d = (dly >= md) ? md - 1'b1 : dly; // R4
        t = dec ? q + {2'b00, md} - {2'b00, d} : q + {2'b00, d}; // R4
        offs = ACC_W'(t % {2'b00, md});
    endfunction

    function automatic logic level(input logic [ACC_W-1:0] acc, input logic [ACC_W-1:0] off,
                                   input logic [ACC_W-1:0] md);
        logic [ACC_W+1:0] p;
        p = ({2'b00, acc} + {2'b00, off}) % {2'b00, md};
        level = p < {3'b000, md[ACC_W-1:1]};
    endfunction

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic wr_done;
    logic [31:0] rd_val;
    logic [NUM_PLL-1:0] en_r, lockpin_r, extout_r, extfb_r, lvds_r;
    logic [NUM_PLL-1:0] gpio_out_r, gpio_oe_r, locked_r, locked_d_r;
    logic [1:0] boost1_r, boost2_r;
    logic [9:0] irq_stat_r, irq_en_r;
    logic [7:0] m_r [NUM_PLL];
    logic [7:0] k_r [NUM_PLL];
    logic [4:0] n_r [NUM_PLL];
    logic [4:0] v_r [NUM_PLL];
    logic [1:0] ph_r [NUM_PLL];
    logic [ACC_W-1:0] dly_r [NUM_PLL];
    logic [NUM_PLL-1:0] dec_r, relock_r;
    logic range_err, combo_err, bad_addr;

    assign wr_done = PSEL_I & PENABLE_I & pready_r & PWRITE_I;

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (CE_I)
        begin
            // one wait state; data and error ready with pready
            pready_r <= PSEL_I & PENABLE_I & ~pready_r;
            if (PSEL_I & PENABLE_I & ~pready_r)
            begin
                prdata_r <= PWRITE_I ? 32'h0000_0000 : rd_val;
                pslverr_r <= bad_addr | (PWRITE_I & (range_err | combo_err));
            end
        end
    end

    // read mux and decode
    always_comb
    begin
        rd_val = 32'h0000_0000;
        bad_addr = 1'b0;
        range_err = 1'b0;
        combo_err = 1'b0;
        unique case (PADDR_I)
            ADDR_CTRL: rd_val = (32'(en_r) << CTRL_EN_LSB) | (32'(lockpin_r) << CTRL_LOCKPIN_LSB)
                                | (32'(extout_r) << CTRL_EXTOUT_LSB) | (32'(extfb_r) << CTRL_EXTFB_LSB)
                                | (32'(lvds_r) << CTRL_LVDS_LSB);
            ADDR_BOOST:
            begin
                rd_val = {28'h000_0000, boost2_r, boost1_r};
                // R10
                combo_err = (PWDATA_I[3:2] == BOOST_BAD) || (PWDATA_I[1:0] > PWDATA_I[3:2]);
            end
            ADDR_STATUS: rd_val = 32'(locked_r) | (32'(LOCK_PIN_I) << STAT_PIN_LSB);
            ADDR_IRQ_STAT: rd_val = 32'(irq_stat_r);
            ADDR_IRQ_CLR: ;
            ADDR_IRQ_EN: rd_val = 32'(irq_en_r);
            ADDR_GPIO: rd_val = 32'(gpio_out_r) | (32'(gpio_oe_r) << GPIO_OE_LSB);
            default: bad_addr = 1'b1;
        endcase
        for (int i = 0; i < NUM_PLL; i++)
        begin
            if (PADDR_I == 8'(ADDR_PLL_BASE + ADDR_PLL_STRIDE * i + OFS_RATIO))
            begin
                bad_addr = 1'b0;
                rd_val = {3'b000, v_r[i], 3'b000, n_r[i], k_r[i], m_r[i]};
                // R1 R2
                range_err = !in_rng(PWDATA_I[RATIO_M_LSB +: 8], MK_MIN, MK_MAX)
                          || !in_rng(PWDATA_I[RATIO_K_LSB +: 8], MK_MIN, MK_MAX)
                          || !in_rng({3'b000, PWDATA_I[RATIO_N_LSB +: 5]}, NV_MIN, NV_MAX)
                          || !in_rng({3'b000, PWDATA_I[RATIO_V_LSB +: 5]}, NV_MIN, NV_MAX);
            end
            if (PADDR_I == 8'(ADDR_PLL_BASE + ADDR_PLL_STRIDE * i + OFS_SHIFT))
            begin
                bad_addr = 1'b0;
                rd_val = (32'(dec_r[i]) << SHIFT_DEC_BIT) | (32'(dly_r[i]) << SHIFT_DLY_LSB)
                       | 32'(ph_r[i]);
            end
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            en_r <= '0;
            lockpin_r <= '0;
            extout_r <= '0;
            extfb_r <= '0;
            lvds_r <= '0;
            gpio_out_r <= '0;
            gpio_oe_r <= '0;
            boost1_r <= BOOST_X1;
            boost2_r <= BOOST_X1;
            irq_en_r <= '0;
        end
        else if (CE_I && wr_done && !pslverr_r)
        begin
            unique case (PADDR_I)
                ADDR_CTRL:
                begin
                    en_r <= PWDATA_I[CTRL_EN_LSB +: NUM_PLL]; // R7
                    lockpin_r <= PWDATA_I[CTRL_LOCKPIN_LSB +: NUM_PLL]; // R6
                    extout_r <= PWDATA_I[CTRL_EXTOUT_LSB +: NUM_PLL]; // R11
                    extfb_r <= PWDATA_I[CTRL_EXTFB_LSB +: NUM_PLL]; // R11
                    // only the lvds-capable plls keep the bit
                    for (int i = 0; i < NUM_PLL; i++)
                        lvds_r[i] <= (i < LVDS_PLLS) & PWDATA_I[CTRL_LVDS_LSB + i]; // R8
                end
                ADDR_BOOST:
                begin
                    boost1_r <= PWDATA_I[1:0]; // R10
                    boost2_r <= PWDATA_I[3:2]; // R10
                end
                ADDR_IRQ_EN: irq_en_r <= PWDATA_I[9:0];
                ADDR_GPIO:
                begin
                    gpio_out_r <= PWDATA_I[0 +: NUM_PLL];
                    gpio_oe_r <= PWDATA_I[GPIO_OE_LSB +: NUM_PLL];
                end
                default: ;
            endcase
        end
    end

    // per-pll ratio and shift; a rejected write leaves old values
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            relock_r <= '0;
            dec_r <= '0;
            for (int i = 0; i < NUM_PLL; i++)
            begin
                m_r[i] <= RST_M;
                k_r[i] <= RST_K;
                n_r[i] <= RST_N;
                v_r[i] <= RST_V;
                ph_r[i] <= 2'h0;
                dly_r[i] <= '0;
            end
        end
        else if (CE_I)
        begin
            relock_r <= '0;
            for (int i = 0; i < NUM_PLL; i++)
            begin
                if (wr_done && !pslverr_r && PADDR_I == 8'(ADDR_PLL_BASE + ADDR_PLL_STRIDE * i + OFS_RATIO))
                begin
                    m_r[i] <= PWDATA_I[RATIO_M_LSB +: 8]; // R1
                    k_r[i] <= PWDATA_I[RATIO_K_LSB +: 8]; // R1
                    n_r[i] <= PWDATA_I[RATIO_N_LSB +: 5]; // R2
                    v_r[i] <= PWDATA_I[RATIO_V_LSB +: 5]; // R2
                    relock_r[i] <= 1'b1;
                end
                if (wr_done && !pslverr_r && PADDR_I == 8'(ADDR_PLL_BASE + ADDR_PLL_STRIDE * i + OFS_SHIFT))
                begin
                    ph_r[i] <= PWDATA_I[SHIFT_PH_LSB +: 2]; // R3
                    dly_r[i] <= PWDATA_I[SHIFT_DLY_LSB +: ACC_W]; // R4
                    dec_r[i] <= PWDATA_I[SHIFT_DEC_BIT]; // R4
                end
            end
        end
    end

    // ----------------------------------------
    // lock detection
    // ----------------------------------------
    logic [LOCK_CNT_W-1:0] lock_cnt_r [NUM_PLL];
    logic [NUM_PLL-1:0] clk_k_r, clk_v_r;

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            locked_r <= '0;
            locked_d_r <= '0;
            for (int i = 0; i < NUM_PLL; i++)
                lock_cnt_r[i] <= '0;
        end
        else if (CE_I)
        begin
            locked_d_r <= locked_r;
            for (int i = 0; i < NUM_PLL; i++)
            begin
                // external loop must return the generated clock unchanged
                if (!CONFIG_DONE_I || !REF_VALID_I || !en_r[i] || relock_r[i]
                    || (extfb_r[i] && EXT_FB_I[i] != clk_k_r[i])) // R12 R14 R11
                begin
                    lock_cnt_r[i] <= '0;
                    locked_r[i] <= 1'b0; // R14
                end
                else if (lock_cnt_r[i] == LOCK_CNT_W'(LOCK_CYC - 1)) // R13
                begin
                    locked_r[i] <= 1'b1; // R5
                end
                else
                begin
                    lock_cnt_r[i] <= lock_cnt_r[i] + 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // clock synthesis
    // ----------------------------------------
    // digital model: output above half the core rate aliases, a real vco does not
    logic [ACC_W-1:0] acc_k_r [NUM_PLL];
    logic [ACC_W-1:0] acc_v_r [NUM_PLL];
    logic [ACC_W-1:0] mod_k [NUM_PLL];
    logic [ACC_W-1:0] mod_v [NUM_PLL];

    always_comb
    begin
        for (int i = 0; i < NUM_PLL; i++)
        begin
            mod_k[i] = ACC_W'({7'h00, n_r[i]} * {4'h0, k_r[i]}); // R1
            mod_v[i] = ACC_W'({7'h00, n_r[i]} * {7'h00, v_r[i]}); // R1
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            clk_k_r <= '0;
            clk_v_r <= '0;
            for (int i = 0; i < NUM_PLL; i++)
            begin
                acc_k_r[i] <= '0;
                acc_v_r[i] <= '0;
            end
        end
        else if (CE_I)
        begin
            for (int i = 0; i < NUM_PLL; i++)
            begin
                if (!CONFIG_DONE_I || !en_r[i] || relock_r[i]) // R12
                begin
                    acc_k_r[i] <= '0;
                    acc_v_r[i] <= '0;
                    clk_k_r[i] <= 1'b0;
                    clk_v_r[i] <= 1'b0;
                end
                else
                begin
                    acc_k_r[i] <= step(acc_k_r[i], m_r[i], mod_k[i]); // R1
                    acc_v_r[i] <= step(acc_v_r[i], m_r[i], mod_v[i]); // R1
                    clk_k_r[i] <= level(acc_k_r[i], offs(ph_r[i], dly_r[i], dec_r[i], mod_k[i]), mod_k[i]);
                    clk_v_r[i] <= level(acc_v_r[i], offs(ph_r[i], dly_r[i], dec_r[i], mod_v[i]), mod_v[i]);
                end
            end
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    logic [NUM_PLL-1:0] clk_k_d_r;

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            LOCK_PIN_O <= '0;
            LOCK_PIN_OE_O <= '0;
            CLK_PAD_O <= '0;
            CLK_PAD_OE_O <= '0;
            SER_STB_O <= '0;
            clk_k_d_r <= '0;
        end
        else if (CE_I)
        begin
            clk_k_d_r <= clk_k_r;
            for (int i = 0; i < NUM_PLL; i++)
            begin
                LOCK_PIN_O[i] <= lockpin_r[i] ? locked_r[i] : gpio_out_r[i]; // R5 R6
                LOCK_PIN_OE_O[i] <= lockpin_r[i] | gpio_oe_r[i]; // R6
                CLK_PAD_O[i] <= extout_r[i] & clk_k_r[i]; // R11
                CLK_PAD_OE_O[i] <= extout_r[i]; // R11
                // sample strobe on each rising edge of the multiplied clock while locked
                SER_STB_O[i] <= lvds_r[i] & locked_r[i] & clk_k_r[i] & ~clk_k_d_r[i]; // R8
            end
        end
    end

    assign CLK_K_O = clk_k_r;
    assign CLK_V_O = clk_v_r;
    assign PREADY_O = pready_r;
    assign PRDATA_O = prdata_r;
    assign PSLVERR_O = pslverr_r;

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    logic [9:0] irq_set;

    always_comb
    begin
        irq_set = '0;
        irq_set[0 +: NUM_PLL] = locked_r & ~locked_d_r;
        irq_set[IRQ_LOSS_LSB +: NUM_PLL] = ~locked_r & locked_d_r;
        irq_set[IRQ_RANGE_BIT] = wr_done & range_err;
        irq_set[IRQ_COMBO_BIT] = wr_done & combo_err;
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            irq_stat_r <= '0;
            IRQ_O <= 1'b0;
        end
        else if (CE_I)
        begin
            // a new event wins over a clear in the same cycle
            irq_stat_r <= (irq_stat_r & ~((wr_done && PADDR_I == ADDR_IRQ_CLR) ? PWDATA_I[9:0] : 10'h000))
                        | irq_set;
            IRQ_O <= |(irq_stat_r & irq_en_r);
        end
    end
endmodule

// ===== bench/pcm_properties.sv
// checker: apb refusals, lock timing, clock pins
// assumes binding to pcm_top; sees only its ports
`timescale 1ns/1ps
module pcm_chk
    import pcm_pkg::*;
#(
    parameter int NUM_PLL = 4,
    parameter int LVDS_PLLS = 2
)(
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic CONFIG_DONE_I,
    input wire logic REF_VALID_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [NUM_PLL-1:0] LOCK_PIN_O,
    input wire logic [NUM_PLL-1:0] LOCK_PIN_OE_O,
    input wire logic [NUM_PLL-1:0] CLK_K_O,
    input wire logic [NUM_PLL-1:0] CLK_V_O,
    input wire logic [NUM_PLL-1:0] CLK_PAD_O,
    input wire logic [NUM_PLL-1:0] CLK_PAD_OE_O,
    input wire logic [NUM_PLL-1:0] SER_STB_O
);
    // ------------------------------
    // helpers
    // ------------------------------
    logic wr_ok, rat, mk_bad, nv_bad, good;
    logic [NUM_PLL-1:0] lp_r;
    logic [LOCK_CNT_W-1:0] cnt_r;
    assign wr_ok = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & CE_I;
    assign rat = PADDR_I >= ADDR_PLL_BASE && PADDR_I[3:0] == 4'h0 && int'(PADDR_I) < int'(ADDR_PLL_BASE) + 16 * NUM_PLL;
    assign mk_bad = PWDATA_I[7:0] < MK_MIN || PWDATA_I[7:0] > MK_MAX
        || PWDATA_I[15:8] < MK_MIN || PWDATA_I[15:8] > MK_MAX;
    assign nv_bad = !(PWDATA_I[20:16] inside {[5'h01:5'h10]}) || !(PWDATA_I[28:24] inside {[5'h01:5'h10]});
    assign good = CONFIG_DONE_I & REF_VALID_I;
    // lock-pin mode mirrored from accepted ctrl writes
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            lp_r <= '0;
        else if (wr_ok && !PSLVERR_O && PADDR_I == ADDR_CTRL)
            lp_r <= PWDATA_I[CTRL_LOCKPIN_LSB +: NUM_PLL];
    end
    // saturating, so a long lock never wraps back below the bound
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            cnt_r <= '0;
        else if (!good)
            cnt_r <= '0;
        else if (cnt_r <= LOCK_CYC)
            cnt_r <= cnt_r + 1'b1;
    end
    // ------------------------------
    // properties
    // ------------------------------
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    AST_RATIO_MK: assert property (wr_ok && rat && mk_bad |-> PSLVERR_O) else $error("m or k accepted");
    AST_RATIO_NV: assert property (wr_ok && rat && !mk_bad |-> PSLVERR_O == nv_bad) else $error("n or v check");
    AST_BOOST_PAIR: assert property (wr_ok && PADDR_I == ADDR_BOOST |-> PSLVERR_O == (PWDATA_I[3:2] == 2'd3 || PWDATA_I[1:0] > PWDATA_I[3:2])) else $error("boost pair");
    AST_PAD_COPY: assert property ((CLK_PAD_O & CLK_PAD_OE_O) == ($past(CLK_K_O) & CLK_PAD_OE_O)) else $error("pad copy");
    AST_SER_LVDS_ONLY: assert property ((SER_STB_O >> LVDS_PLLS) == '0) else $error("strobe on plain pll");
    AST_SER_GAP: assert property ((SER_STB_O & $past(SER_STB_O)) == '0) else $error("strobe too long");
    AST_CFG_QUIET: assert property (!CONFIG_DONE_I ##1 !CONFIG_DONE_I |-> (CLK_K_O | CLK_V_O | SER_STB_O) == '0) else $error("clock before config");
    AST_LOCK_DROP: assert property (!good |-> ##2 (LOCK_PIN_O & lp_r) == '0) else $error("lock kept");
    AST_LOCK_EARLY: assert property ((LOCK_PIN_O & lp_r) != '0 && good && $past(good) |-> cnt_r > LOCK_CYC) else $error("early lock");
    AST_LOCK_OE: assert property (lp_r == $past(lp_r) |-> (LOCK_PIN_OE_O & lp_r) == lp_r) else $error("lock pin idle");
endmodule

bind pcm_top pcm_chk #(.NUM_PLL(NUM_PLL), .LVDS_PLLS(LVDS_PLLS)) u_chk (.*);

// ===== bench/pcm_board.sv
// board model: reference source, feedback trace, pulled-up lock pins
// assumes the bench steers ref_on_i and fb_cut_i
`timescale 1ns/1ps
module pcm_board
#(
    parameter int NUM_PLL = 4
)(
    input wire logic ref_on_i,
    input wire logic fb_cut_i,
    input wire logic [NUM_PLL-1:0] clk_k_i,
    input wire logic [NUM_PLL-1:0] pin_o_i,
    input wire logic [NUM_PLL-1:0] pin_oe_i,
    output logic ref_valid_o,
    output logic [NUM_PLL-1:0] ext_fb_o,
    output logic [NUM_PLL-1:0] pin_lvl_o
);
    // reference on the shared pin only; secondary pin left unconnected
    assign ref_valid_o = ref_on_i;
    // a damaged trace returns the wrong level every cycle
    assign ext_fb_o = fb_cut_i ? ~clk_k_i : clk_k_i;
    // pull-ups: a released pin reads high
    assign pin_lvl_o = (pin_o_i & pin_oe_i) | ~pin_oe_i;
endmodule

// ===== bench/pcm_top_tb.sv
// self-checking bench: apb, ratios, pairs, lock
// assumes pcm_top, pcm_board and the bound checker compiled first
`timescale 1ns/1ps
module pcm_top_tb
    import pcm_pkg::*;
;
    localparam int NP = 4;
    typedef struct {logic rd; logic [31:0] d; logic e;} pcm_exp_t;
    // {refused, word}: m and n at and just past both limits; k and v just past the low limit and at the high one
    localparam logic [32:0] RT [10] = '{33'h1_0101_0201, 33'h0_0101_02A0, 33'h1_0101_02A1, 33'h1_0101_0102,
        33'h0_0101_A002, 33'h1_0100_0202, 33'h0_0110_0202, 33'h1_0111_0202, 33'h1_0001_0202, 33'h0_1001_0202};
    logic clk, rst_n, cfg, ref_on, fb_cut, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, irq, ref_valid;
    logic [NP-1:0] ext_fb, pin_in, pin_o, pin_oe, clk_k, clk_v, pad, pad_oe, stb;
    pcm_exp_t q[$];
    pcm_exp_t ex;
    int fails, n_checks;
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    pcm_top #(.NUM_PLL(NP), .LVDS_PLLS(2)) dut (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .CONFIG_DONE_I(cfg), .REF_VALID_I(ref_valid),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_FB_I(ext_fb), .LOCK_PIN_I(pin_in),
        .LOCK_PIN_O(pin_o), .LOCK_PIN_OE_O(pin_oe), .CLK_K_O(clk_k), .CLK_V_O(clk_v), .CLK_PAD_O(pad),
        .CLK_PAD_OE_O(pad_oe), .SER_STB_O(stb), .IRQ_O(irq));
    pcm_board #(.NUM_PLL(NP)) board (.ref_on_i(ref_on), .fb_cut_i(fb_cut), .clk_k_i(clk_k), .pin_o_i(pin_o),
        .pin_oe_i(pin_oe), .ref_valid_o(ref_valid), .ext_fb_o(ext_fb), .pin_lvl_o(pin_in));
    // ------------------------------
    // tasks
    // ------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x,
        input logic e);
        q.push_back('{!wr, x, e});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // answers compared in order, at the edge that takes them
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            ex = q.pop_front();
            if (ex.rd)
                chk(prdata, ex.d, "read data");
            chk(32'(pslverr), 32'(ex.e), "slave error");
        end
    end
    initial
    begin
        #80000;
        fails++;
        close_out();
    end
    // ------------------------------
    // scenarios
    // ------------------------------
    initial
    begin
        int t, nk, nv, ns;
        logic [31:0] r;
        logic [NP-1:0] pk, pv;
        {psel, penable, pwrite, rst_n, cfg, fb_cut, paddr, pwdata} = '0;
        ref_on = 1'b1;
        r = 32'h0101_0202;
        void'($urandom(32'h38b4_a360));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, ADDR_PLL_BASE, '0, r, 1'b0);
        apb(1'b0, 8'h1C, '0, '0, 1'b1);
        foreach (RT[i])
        begin
            apb(1'b1, 8'h30, RT[i][31:0], '0, RT[i][32]);
            if (!RT[i][32])
                r = RT[i][31:0];
            apb(1'b0, 8'h30, '0, r, 1'b0);
        end
        repeat (4)
        begin
            r = {3'h0, 5'($urandom_range(16, 1)), 3'h0, 5'($urandom_range(16, 1)),
                8'($urandom_range(160, 2)), 8'($urandom_range(160, 2))};
            apb(1'b1, 8'h50, r, '0, 1'b0);
            apb(1'b0, 8'h50, '0, r, 1'b0);
        end
        for (int c = 0; c < 16; c++)
            apb(1'b1, ADDR_BOOST, 32'(c), '0, c[3:2] == 2'd3 || c[1:0] > c[3:2]);
        apb(1'b0, ADDR_BOOST, '0, 32'h0000_000A, 1'b0);
        apb(1'b0, ADDR_IRQ_STAT, '0, 32'h0000_0300, 1'b0);
        for (int b = 1; b >= 0; b--)
        begin
            apb(1'b1, ADDR_IRQ_EN, 32'(b) << IRQ_RANGE_BIT, '0, 1'b0);
            repeat (2) @(posedge clk);
            chk(32'(irq), 32'(b), "irq level");
        end
        apb(1'b1, ADDR_IRQ_CLR, 32'h0000_0300, '0, 1'b0);
        apb(1'b0, ADDR_IRQ_STAT, '0, 32'h0000_0000, 1'b0);
        // pll0: k period 4 cycles, v period 2 cycles
        apb(1'b1, ADDR_PLL_BASE, 32'h0202_0402, '0, 1'b0);
        apb(1'b1, ADDR_IRQ_EN, 32'h0000_0011, '0, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0001_1111, '0, 1'b0);
        repeat (2600) @(posedge clk);
        chk(32'(pin_o[0] | clk_k[0]), 32'h0, "active before config");
        cfg <= 1'b1;
        t = 0;
        while (pin_o[0] !== 1'b1 && t < 3000)
        begin
            @(posedge clk);
            t++;
        end
        chk(32'(t >= LOCK_CYC && t <= LOCK_CYC + 4), 32'h1, "lock time");
        apb(1'b0, ADDR_STATUS, '0, 32'h0000_00F1, 1'b0);
        chk(32'(irq), 32'h1, "lock irq");
        chk(32'(pad_oe[0]), 32'h1, "pad drive");
        {nk, nv, ns} = '0;
        pk = clk_k;
        pv = clk_v;
        repeat (400)
        begin
            @(posedge clk);
            nk += int'(clk_k[0] & ~pk[0]);
            nv += int'(clk_v[0] & ~pv[0]);
            ns += int'(stb[0]);
            pk = clk_k;
            pv = clk_v;
        end
        chk(nk, 100, "k edges");
        chk(nv, 200, "v edges");
        chk(ns, 100, "strobes");
        ref_on <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(pin_o[0]), 32'h0, "lock after loss");
        apb(1'b0, ADDR_IRQ_STAT, '0, 32'h0000_0011, 1'b0);
        ref_on <= 1'b1;
        fb_cut <= 1'b1;
        repeat (2700) @(posedge clk);
        chk(32'(pin_o[0]), 32'h0, "lock on cut trace");
        chk(32'(q.size()), 32'h0, "answers left");
        close_out();
    end
endmodule
